// ---- rtl/otfs_pkg.sv ----
// Package for the overtemperature fault supervisor: constants and carrier types
package otfs_pkg;
	localparam int NUM_CH = 5;
	localparam int CLK_MHZ = 40;
	// Deglitch time, least figure in us, rounded up to cycles
	localparam int DEGLITCH_MIN_US = 2;
	localparam int DEGLITCH_CYC = DEGLITCH_MIN_US * CLK_MHZ;
	// Autorestart, nominal figure in ms
	localparam int AUTORESTART_MS = 64;
	localparam int AUTORESTART_CYC = AUTORESTART_MS * 1000 * CLK_MHZ;
	// Wake-up blanking, nominal figure in us
	localparam int BLANKING_US = 50;
	localparam int BLANKING_CYC = BLANKING_US * CLK_MHZ;
	localparam int DG_W = 8;
	localparam int AR_W = 22;
	localparam int BL_W = 12;
	localparam logic WARN_SEL_RST = 1'h0;
	// Per channel comparator results
	typedef struct packed {
		logic warn_hi;
		logic warn_lo;
		logic shut;
	} otfs_temp_t;
	// Per channel reported status
	typedef struct packed {
		logic heat_warning;
		logic heat_shutdown;
	} otfs_stat_t;
endpackage

// ---- rtl/otfs_channel.sv ----
// One channel of overtemperature warning, deglitch and shutdown latch
`timescale 1ns/100ps
`default_nettype none
module otfs_channel
	import otfs_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire otfs_temp_t temp,
	input wire logic warn_sel,
	input wire logic blank,
	input wire logic fail_mode,
	input wire logic status_read,
	input wire logic on_write,
	input wire logic mode_change,
	input wire logic retry,
	output var otfs_stat_t stat,
	output logic out_enable
);
	logic [DG_W-1:0] dg_cnt_ff;
	logic [DG_W-1:0] nxt_dg_cnt;
	logic warn_ff;
	logic shut_ff;
	logic off_ff;
	logic [1:0] rd_arm_ff;
	// Selected warning comparator for this channel
	wire warn_now = warn_sel ? temp.warn_lo : temp.warn_hi;
	wire shut_now = temp.shut & ~blank;
	wire warn_ev = warn_now & ~blank;
	wire trip = shut_now && (dg_cnt_ff == DG_W'(DEGLITCH_CYC - 1));
	// Restart only when the condition has gone
	wire restart = off_ff & ~temp.shut & ((~fail_mode & on_write) | (fail_mode & mode_change));
	wire clr_warn = status_read & rd_arm_ff[1];
	wire clr_shut = status_read & rd_arm_ff[0];

	// Deglitch counter restarts on any dropout of the shutdown compare
	assign nxt_dg_cnt = !shut_now ? '0 : (trip ? dg_cnt_ff : dg_cnt_ff + DG_W'(1));

	// Counter register
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			dg_cnt_ff <= '0;
		end else begin
			dg_cnt_ff <= nxt_dg_cnt;
		end
	end

	// A read clears a flag only once its condition has gone; a new event wins
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			warn_ff <= 1'h0;
			shut_ff <= 1'h0;
			off_ff <= 1'h0;
			rd_arm_ff <= 2'h0;
		end else begin
			warn_ff <= warn_ev | (warn_ff & ~clr_warn);
			shut_ff <= trip | (shut_ff & ~clr_shut);
			off_ff <= trip | (off_ff & ~restart & ~(fail_mode & retry & ~temp.shut));
			rd_arm_ff <= {~warn_now, ~temp.shut};
		end
	end

	// Output gating is a single flop so the switch-off lands with the status
	assign out_enable = ~off_ff;
	assign stat.heat_warning = warn_ff;
	assign stat.heat_shutdown = shut_ff;
endmodule
`default_nettype wire

// ---- rtl/otfs_top.sv ----
// Top of the five channel overtemperature fault supervisor
// Overview of operation
// - Each of five channels protected independently.
// - Warning flags status, output stays unchanged.
// - Shutdown after deglitch, status set in the same cycle.
// - Report in quick and channel status.
// - Select bit zero high, one low threshold.
// - Warning clears: temperature low, then read.
// - Normal mode restart needs ON write.
// - Shutdown latched until gone, then read.
// - Fail mode restart needs mode transition.
// - Fail mode autorestart retry every 64 ms.
// - Ignore faults during wake-up blanking.
`timescale 1ns/100ps
`default_nettype none
module otfs_top
	import otfs_pkg::*;
#(
	parameter int AUTORESTART_CYCLES = AUTORESTART_CYC,
	parameter int BLANKING_CYCLES = BLANKING_CYC
)
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire otfs_temp_t [NUM_CH-1:0] temp_pins,
	input wire logic warn_threshold_select,
	input wire logic fail_mode,
	input wire logic wake_up,
	input wire logic mode_change,
	input wire logic [NUM_CH-1:0] status_read,
	input wire logic [NUM_CH-1:0] on_write,
	input wire logic quick_status_read,
	output var otfs_stat_t [NUM_CH-1:0] channel_status,
	output var otfs_stat_t quick_status,
	output logic [NUM_CH-1:0] out_enable,
	output logic blanking
);
	// Two stage synchroniser for the comparator levels
	otfs_temp_t [NUM_CH-1:0] temp_s1_ff;
	otfs_temp_t [NUM_CH-1:0] temp_s2_ff;

	// Wake-up blanking counter, its next value and end of window
	logic [BL_W-1:0] bl_cnt_ff;
	logic [BL_W-1:0] nxt_bl_cnt;
	logic bl_done;

	// Autorestart interval counter, its next value and the retry tick
	logic [AR_W-1:0] ar_cnt_ff;
	logic [AR_W-1:0] nxt_ar_cnt;
	logic ar_tick;

	// Shared threshold select, one flop for all channels
	logic sel_ff;

	// Quick status flops and their next values
	otfs_stat_t qs_ff;
	logic nxt_qs_warn;
	logic nxt_qs_shut;

	// Per channel flags gathered for the quick status
	logic [NUM_CH-1:0] w_any;
	logic [NUM_CH-1:0] s_any;
	logic any_warn;
	logic any_shut;

	// Pin synchroniser; comparators are asynchronous to clk
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			temp_s1_ff <= '0;
			temp_s2_ff <= '0;
		end else begin
			temp_s1_ff <= temp_pins;
			temp_s2_ff <= temp_s1_ff;
		end
	end

	// Select bit registered once, shared by all channels
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			sel_ff <= WARN_SEL_RST;
		end else begin
			sel_ff <= warn_threshold_select;
		end
	end

	// Blanking window decode; a standing wake-up keeps the window open
	assign bl_done = (bl_cnt_ff == BL_W'(BLANKING_CYCLES));
	assign nxt_bl_cnt = wake_up ? '0 : (bl_done ? bl_cnt_ff : bl_cnt_ff + BL_W'(1));
	assign blanking = ~bl_done;

	// Blanking counter; saturates so the window never reopens by itself
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			bl_cnt_ff <= '0;
		end else begin
			bl_cnt_ff <= nxt_bl_cnt;
		end
	end

	// Autorestart tick decode; held at zero outside fail mode
	assign ar_tick = (ar_cnt_ff == AR_W'(AUTORESTART_CYCLES - 1));
	assign nxt_ar_cnt = (!fail_mode || ar_tick) ? '0 : ar_cnt_ff + AR_W'(1);

	// Autorestart counter; one shared interval, so retries align
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			ar_cnt_ff <= '0;
		end else begin
			ar_cnt_ff <= nxt_ar_cnt;
		end
	end

	// One channel instance each
	genvar g;
	generate
		for (g = 0; g < NUM_CH; g++) begin : g_ch
			otfs_channel u_ch (
				.clk(clk),
				.sys_rst(sys_rst),
				.temp(temp_s2_ff[g]),
				.warn_sel(sel_ff),
				.blank(blanking),
				.fail_mode(fail_mode),
				.status_read(status_read[g]),
				.on_write(on_write[g]),
				.mode_change(mode_change),
				.retry(ar_tick),
				.stat(channel_status[g]),
				.out_enable(out_enable[g])
			);
			assign w_any[g] = channel_status[g].heat_warning;
			assign s_any[g] = channel_status[g].heat_shutdown;
		end
	endgenerate

	// Quick status gather; a standing channel flag beats a quick read
	assign any_warn = |w_any;
	assign any_shut = |s_any;
	assign nxt_qs_warn = any_warn | (qs_ff.heat_warning & ~quick_status_read);
	assign nxt_qs_shut = any_shut | (qs_ff.heat_shutdown & ~quick_status_read);

	// Quick status register, one cycle behind the channel flags
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			qs_ff <= '0;
		end else begin
			qs_ff.heat_warning <= nxt_qs_warn;
			qs_ff.heat_shutdown <= nxt_qs_shut;
		end
	end
	assign quick_status = qs_ff;
endmodule
`default_nettype wire

// ---- test/otfs_top_sva.sv ----
// Port checker for the overtemperature supervisor
`timescale 1ns/100ps
`default_nettype none
module otfs_top_sva
	import otfs_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire otfs_temp_t [NUM_CH-1:0] temp_pins,
	input wire logic [NUM_CH-1:0] status_read,
	input wire otfs_stat_t [NUM_CH-1:0] channel_status,
	input wire otfs_stat_t quick_status,
	input wire logic [NUM_CH-1:0] out_enable,
	input wire logic blanking
);
	wire logic sd0 = channel_status[0].heat_shutdown;
	wire logic wn2 = channel_status[2].heat_warning;
	// Reset masks stale past values at release
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	// Pin hot at the first and at the last sample of the deglitch run
	sequence hot_run;
		$past(temp_pins[0].shut, 3) && $past(temp_pins[0].shut, 82);
	endsequence
	dg_run_a: assert property ($rose(sd0) |-> hot_run) else $error("short run");
	off_flag_a: assert property ($fell(out_enable[0]) |-> $rose(sd0)) else $error("no flag");
	quick_sd_a: assert property ($rose(sd0) |=> quick_status.heat_shutdown) else $error("quick");
	warn_on_a: assert property ($rose(wn2) |-> $stable(out_enable[2])) else $error("moved");
	warn_hold_a: assert property (wn2 && !status_read[2] |=> wn2) else $error("warn lost");
	sd_hold_a: assert property (sd0 && !status_read[0] |=> sd0) else $error("sd lost");
	blank_ign_a: assert property (blanking |=> !$rose(sd0) && !$rose(wn2)) else $error("blank");
	own_chan_a: assert property ($fell(out_enable[1]) |-> $past(temp_pins[1].shut, 4)) else $error("ch");
endmodule
bind otfs_top otfs_top_sva u_sva (.clk(clk), .sys_rst(sys_rst), .temp_pins(temp_pins),
	.status_read(status_read), .channel_status(channel_status), .quick_status(quick_status),
	.out_enable(out_enable), .blanking(blanking));
`default_nettype wire

// ---- test/otfs_mcu.sv ----
// Controller model: status reads and ON-bit writes as one-cycle pulses
`timescale 1ns/100ps
`default_nettype none
module otfs_mcu
	import otfs_pkg::*;
(
	input wire logic clk,
	output logic [NUM_CH-1:0] rd,
	output logic [NUM_CH-1:0] wr
);
	initial {rd, wr} = 10'h000;
	// Pulses rise after an edge and are sampled at exactly one edge
	task automatic read(input int c);
		@(posedge clk) #2 rd[c] = 1'h1;
		@(posedge clk) #2 rd[c] = 1'h0;
	endtask
	task automatic write(input int c);
		@(posedge clk) #2 wr[c] = 1'h1;
		@(posedge clk) #2 wr[c] = 1'h0;
	endtask
endmodule
`default_nettype wire

// ---- test/test_otfs_top.sv ----
// Bench for the overtemperature fault supervisor
`timescale 1ns/100ps
`default_nettype none
module test_otfs_top import otfs_pkg::*; ;
	logic clk = 1'h0, sys_rst = 1'h1, fail_mode = 1'h0, blanking;
	logic warn_threshold_select = 1'h0, wake_up = 1'h0, mode_change = 1'h0;
	logic quick_status_read = 1'h0;
	otfs_temp_t [NUM_CH-1:0] temp_pins = 15'h0;
	otfs_stat_t [NUM_CH-1:0] channel_status;
	otfs_stat_t quick_status;
	logic [NUM_CH-1:0] status_read, on_write, out_enable;
	int num_errors = 0, check_count = 0;
	// 40 MHz clock
	always #12.5 clk = ~clk;
	// Short timers keep the run brief
	otfs_top #(.AUTORESTART_CYCLES(50), .BLANKING_CYCLES(10)) u_dut (.*);
	otfs_mcu u_mcu (.clk(clk), .rd(status_read), .wr(on_write));
	task automatic wt(input int n);
		repeat (n) @(posedge clk);
		#2;
	endtask
	task automatic chk(input logic [17:0] s, input logic [17:0] e);
		check_count++;
		if (s !== e) begin
			num_errors++;
			$display("CHECK FAILED at %0t: saw %h want %h", $time, s, e);
		end
	endtask
	task automatic close_out;
		$display("%0d checks, %0d mismatches", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// Warning, shutdown and fail mode runs in turn
	initial begin
		repeat (20) @(posedge clk);
		#2 sys_rst = 1'h0;
		chk({blanking, out_enable, channel_status}, 16'hFC00);
		temp_pins = 15'h500;
		wt(20);
		chk({blanking, quick_status, out_enable, channel_status}, 18'h17C20);
		warn_threshold_select = 1'h1;
		temp_pins = 15'h400;
		wt(6);
		u_mcu.read(2);
		u_mcu.read(3);
		chk(channel_status, 10'h080);
		$display("warning test done");
		temp_pins = 15'h401;
		wt(80);
		chk(out_enable, 5'h1F);
		wt(4);
		chk({out_enable, channel_status[0], quick_status}, 9'h1E7);
		u_mcu.read(0);
		u_mcu.write(0);
		chk({out_enable[0], channel_status[0]}, 3'h1);
		temp_pins = 15'h400;
		wt(4);
		u_mcu.write(0);
		u_mcu.read(0);
		chk({out_enable[0], channel_status[0]}, 3'h4);
		$display("shutdown test done");
		quick_status_read = 1'h1;
		wt(1);
		quick_status_read = 1'h0;
		chk(quick_status, 2'h2);
		$display("quick status test done");
		fail_mode = 1'h1;
		temp_pins = 15'h408;
		wt(90);
		u_mcu.write(1);
		chk(out_enable[1], 1'h0);
		temp_pins = 15'h400;
		wt(3);
		mode_change = 1'h1;
		wt(1);
		mode_change = 1'h0;
		chk(out_enable[1], 1'h1);
		temp_pins = 15'h408;
		wt(84);
		chk(out_enable[1], 1'h0);
		temp_pins = 15'h400;
		for (int i = 0; i < 60 && out_enable[1] !== 1'h1; i++)
			wt(1);
		chk(out_enable[1], 1'h1);
		$display("fail mode test done");
		wake_up = 1'h1;
		wt(1);
		wake_up = 1'h0;
		chk(blanking, 1'h1);
		wt(11);
		chk(blanking, 1'h0);
		$display("wake-up test done");
		close_out;
	end
endmodule
`default_nettype wire
